// ===== src/sfx_consts.svh
`ifndef SFX_CONSTS_SVH
`define SFX_CONSTS_SVH
`define SFX_NUM_COND 6
`define SFX_PRE_MASK 6'h07
`define SFX_POST_MASK 6'h38
`define SFX_ID_SAVE_BIT 24
`define SFX_ID_VEC1_BIT 25
`define SFX_ID_VEC2_BIT 26
`define SFX_OS_SAVE_BIT 9
`define SFX_OS_VEC_EXC_BIT 10
`define SFX_NATIVE_ERR_BIT 5
`define SFX_EMUL_BIT 2
`endif

// ===== src/sfx_pkg.sv
package sfx_pkg;
    typedef enum logic [2:0] {
        SFX_IDLE,
        SFX_PRE_CHECK,
        SFX_PRE_FAULT,
        SFX_POST_CHECK,
        SFX_POST_FAULT,
        SFX_COMPLETE
    } sfx_state_t;
    typedef struct packed {
        sfx_state_t state;
        logic [5:0] flags;
        logic vec_fault;
        logic ud_fault;
        logic write_result;
        logic done;
        logic busy;
        logic legacy_err;
        logic [5:0] cond_hold;
        logic [1:0] vec_round;
        logic [1:0] legacy_round;
        logic [31:0] id_word;
    } sfx_regs_t;
endpackage

// ===== src/sfx_seq.sv
`timescale 1ns/100ps
`include "sfx_consts.svh"
module sfx_seq #(
    parameter int NUM_COND = `SFX_NUM_COND
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // instruction issue
    input wire logic insn_start,
    input wire logic insn_supported,
    input wire logic [NUM_COND-1:0] insn_cond,
    input wire logic [NUM_COND-1:0] vec_mask,
    input wire logic [1:0] vec_round,
    input wire logic handler_return,
    input wire logic flags_clear,
    // control bits
    input wire logic os_vector_exception_support_bit,
    input wire logic os_state_save_support_bit,
    input wire logic native_error_mode_bit,
    input wire logic ignore_numeric_error_pin,
    input wire logic legacy_error_in,
    input wire logic [1:0] legacy_round,
    // results
    output logic [NUM_COND-1:0] sticky_flags,
    output logic vector_fp_fault,
    output logic undefined_opcode_fault,
    output logic result_write,
    output logic insn_done,
    output logic seq_busy,
    output logic legacy_fp_error_pin,
    output logic [1:0] vec_round_used,
    output logic [1:0] legacy_round_used,
    output logic [31:0] id_leaf1
);
    import sfx_pkg::*;

    sfx_regs_t s_reg;
    sfx_regs_t s_next;
    logic rst_meta;
    logic rst_sync_n;
    logic [NUM_COND-1:0] hit;
    logic [NUM_COND-1:0] phase_mask;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // fault only on a new occurrence in this phase, never from a stale flag
    function automatic logic unmasked_hit(input logic [NUM_COND-1:0] c,
                                          input logic [NUM_COND-1:0] m);
        unmasked_hit = |(c & ~m);
    endfunction

    always_comb
    begin
        s_next = s_reg;
        s_next.vec_fault = 1'b0;
        s_next.ud_fault = 1'b0;
        s_next.write_result = 1'b0;
        s_next.done = 1'b0;
        phase_mask = NUM_COND'(`SFX_PRE_MASK);
        if (s_reg.state == SFX_POST_CHECK)
            phase_mask = NUM_COND'(`SFX_POST_MASK);
        hit = s_reg.cond_hold & phase_mask;
        if (flags_clear)
            s_next.flags = '0;
        // sticky set wins over clear; masked and unmasked alike
        if (s_reg.state == SFX_PRE_CHECK || s_reg.state == SFX_POST_CHECK)
            s_next.flags = s_next.flags | hit;
        // legacy error pin follows only the legacy unit
        s_next.legacy_err = legacy_error_in;
        // separate rounding paths, no cross coupling
        s_next.vec_round = vec_round;
        s_next.legacy_round = legacy_round;
        s_next.id_word = 32'h0;
        s_next.id_word[`SFX_ID_SAVE_BIT] = 1'b1;
        s_next.id_word[`SFX_ID_VEC1_BIT] = 1'b1;
        s_next.id_word[`SFX_ID_VEC2_BIT] = 1'b1;
        case (s_reg.state)
            SFX_IDLE:
            begin
                if (insn_start)
                begin
                    s_next.busy = 1'b1;
                    if (!insn_supported)
                    begin
                        s_next.ud_fault = 1'b1;
                        s_next.state = SFX_COMPLETE;
                    end
                    else
                        s_next.state = SFX_PRE_CHECK;
                end
            end
            SFX_PRE_CHECK, SFX_POST_CHECK:
            begin
                if (unmasked_hit(hit, vec_mask))
                begin
                    // os opt-in decides between the two faults
                    if (!os_vector_exception_support_bit)
                        s_next.ud_fault = 1'b1;
                    else
                        s_next.vec_fault = 1'b1;
                    s_next.state = (s_reg.state == SFX_PRE_CHECK) ? SFX_PRE_FAULT
                                                                   : SFX_POST_FAULT;
                end
                else if (s_reg.state == SFX_PRE_CHECK)
                    s_next.state = SFX_POST_CHECK;
                else
                    s_next.state = SFX_COMPLETE;
            end
            SFX_PRE_FAULT:
            begin
                if (handler_return)
                    s_next.state = SFX_POST_CHECK;
            end
            SFX_POST_FAULT:
            begin
                if (handler_return)
                    s_next.state = SFX_COMPLETE;
            end
            SFX_COMPLETE:
            begin
                // masked results held back until here
                s_next.write_result = ~s_reg.ud_fault;
                s_next.done = 1'b1;
                s_next.busy = 1'b0;
                s_next.state = SFX_IDLE;
            end
            default:
                s_next.state = SFX_IDLE;
        endcase
        // handler may fix operands, so the conditions are resampled at each check
        if (s_next.state == SFX_PRE_CHECK || s_next.state == SFX_POST_CHECK)
            s_next.cond_hold = 6'(insn_cond);
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            s_reg <= '{state: SFX_IDLE, default: '0};
        else
            s_reg <= s_next;
    end

    assign sticky_flags = s_reg.flags;
    assign vector_fp_fault = s_reg.vec_fault;
    assign undefined_opcode_fault = s_reg.ud_fault;
    assign result_write = s_reg.write_result;
    assign insn_done = s_reg.done;
    assign seq_busy = s_reg.busy;
    assign legacy_fp_error_pin = s_reg.legacy_err;
    assign vec_round_used = s_reg.vec_round;
    assign legacy_round_used = s_reg.legacy_round;
    assign id_leaf1 = s_reg.id_word;

    pre_fault_os_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        (s_reg.state == SFX_PRE_CHECK && unmasked_hit(hit, vec_mask)
         && !os_vector_exception_support_bit) |=> undefined_opcode_fault && !vector_fp_fault)
        else $error("missing undefined opcode fault");
    resume_post_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        (s_reg.state == SFX_PRE_FAULT && handler_return) |=> s_reg.state == SFX_POST_CHECK)
        else $error("no resume to post check");
    done_after_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        (s_reg.state == SFX_POST_FAULT && handler_return) |=> ##1 insn_done)
        else $error("completion late");
    flag_set_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        (s_reg.state == SFX_POST_CHECK) |=> ((sticky_flags & $past(hit)) == $past(hit)))
        else $error("flag not set");
    hold_result_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        (s_reg.state == SFX_POST_FAULT) |=> !result_write)
        else $error("result written early");
    legacy_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        vector_fp_fault && !$past(legacy_error_in) |-> !legacy_fp_error_pin)
        else $error("vector fault on legacy pin");
    unsup_op_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        (s_reg.state == SFX_IDLE && insn_start && !insn_supported)
        |=> undefined_opcode_fault ##1 !result_write && insn_done)
        else $error("unsupported op not refused");
    no_stale_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        (s_reg.state == SFX_PRE_CHECK && hit == '0) |=> !vector_fp_fault)
        else $error("fault without new condition");
    id_bits_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
        $past(rst_sync_n) |-> id_leaf1[26:24] == 3'h7)
        else $error("id bits wrong");
endmodule

// ===== testbench/sfx_seq_tb_top.sv
`timescale 1ns/100ps
module sfx_seq_tb_top;
    logic clk_sys = 0, reset_n = 0, insn_start = 0, insn_supported = 1, handler_return = 0;
    // os has set both support bits
    // no flush-to-zero, denormals-zero or emulation inputs: software keeps them clear
    logic flags_clear = 0, os_vec = 1, os_fx = 1, native_mode = 0, ignore_pin = 0, leg_err = 0;
    logic [5:0] insn_cond = 0, vec_mask = 6'h3f, sticky_flags;
    logic [1:0] vec_round = 0, legacy_round = 0, vec_round_used, legacy_round_used;
    logic vec_f, ud_f, result_write, insn_done, seq_busy, leg_pin;
    logic [31:0] id_leaf1;
    int mismatches = 0, check_count = 0, cycles = 0, nv, nu, nw;
    sfx_seq uut (.clk_sys(clk_sys), .reset_n(reset_n), .insn_start(insn_start),
        .insn_supported(insn_supported), .insn_cond(insn_cond), .vec_mask(vec_mask),
        .vec_round(vec_round), .handler_return(handler_return), .flags_clear(flags_clear),
        .os_vector_exception_support_bit(os_vec), .os_state_save_support_bit(os_fx),
        .native_error_mode_bit(native_mode), .ignore_numeric_error_pin(ignore_pin),
        .legacy_error_in(leg_err), .legacy_round(legacy_round), .sticky_flags(sticky_flags),
        .vector_fp_fault(vec_f), .undefined_opcode_fault(ud_f), .result_write(result_write),
        .insn_done(insn_done), .seq_busy(seq_busy), .legacy_fp_error_pin(leg_pin),
        .vec_round_used(vec_round_used), .legacy_round_used(legacy_round_used),
        .id_leaf1(id_leaf1));
    always #2.5 clk_sys = ~clk_sys;
    // ceiling well above the seventy or so cycles the scenarios need
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic clear_flags();
        flags_clear = 1;
        tick(1);
        flags_clear = 0;
        tick(1);
    endtask
    // handler answers every fault in the same cycle it shows
    task automatic run_insn(input logic [5:0] cond, input logic [5:0] mask, input logic sup);
        int i;
        nv = 0;
        nu = 0;
        nw = 0;
        insn_cond = cond;
        vec_mask = mask;
        insn_supported = sup;
        insn_start = 1;
        tick(1);
        insn_start = 0;
        for (i = 0; i < 40; i++)
        begin
            handler_return = (vec_f === 1'b1) || (ud_f === 1'b1);
            nv += (vec_f === 1'b1);
            nu += (ud_f === 1'b1);
            nw += (result_write === 1'b1);
            if (result_write === 1'b1) check("write with done", insn_done, 1);
            if (leg_pin !== 1'b0) check("legacy pin", leg_pin, 0);
            if (insn_done === 1'b1 || (nu > 0 && seq_busy === 1'b0)) break;
            tick(1);
        end
        handler_return = 0;
        check("insn end", i < 40, 1);
        check("busy end", seq_busy, 0);
        tick(1);
    endtask
    task automatic sc_clean();
        clear_flags();
        run_insn(6'h00, 6'h00, 1);
        check("clean faults", nv + nu, 0);
        check("clean write", nw, 1);
        check("id bits", id_leaf1[26:24], 3'h7);
    endtask
    task automatic sc_twice();
        clear_flags();
        ignore_pin = 1;
        native_mode = 1;
        run_insn(6'h09, 6'h00, 1);
        check("two faults", nv, 2);
        check("no ud with pin", nu, 0);
        check("resumed write", nw, 1);
        check("ored flags", sticky_flags, 6'h09);
        ignore_pin = 0;
    endtask
    task automatic sc_mixed();
        clear_flags();
        run_insn(6'h3f, 6'h36, 1);
        check("mixed faults", nv, 2);
        check("mixed flags", sticky_flags, 6'h3f);
        check("mixed write", nw, 1);
    endtask
    task automatic sc_os_off();
        clear_flags();
        os_vec = 0;
        run_insn(6'h01, 6'h00, 1);
        check("ud no os", nu, 1);
        check("xf no os", nv, 0);
        check("pre flags", sticky_flags, 6'h01);
        os_vec = 1;
    endtask
    task automatic sc_unsup();
        run_insn(6'h00, 6'h3f, 0);
        check("ud unsupported", nu, 1);
        check("no write", nw, 0);
    endtask
    task automatic sc_sticky();
        clear_flags();
        run_insn(6'h04, 6'h3f, 1);
        check("masked flag", sticky_flags, 6'h04);
        run_insn(6'h00, 6'h00, 1);
        check("no late fault", nv, 0);
    endtask
    task automatic sc_legacy();
        leg_err = 1;
        vec_round = 2'h2;
        legacy_round = 2'h1;
        tick(1);
        check("legacy err", leg_pin, 1);
        tick(1);
        check("vec round", vec_round_used, 2'h2);
        check("leg round", legacy_round_used, 2'h1);
        leg_err = 0;
        tick(2);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys);
        #1;
        reset_n = 1;
        // synchroniser needs its two edges before the first start
        tick(3);
        sc_clean();
        sc_twice();
        sc_mixed();
        sc_os_off();
        sc_unsup();
        sc_sticky();
        sc_legacy();
        give_verdict();
    end
endmodule
